// ### hw/bit_and_logic_instr_exec.v
// Execute stage with file registers, accumulator and status flags
`timescale 1ns/1ps
`include "bit_logic_exec_defines.vh"

module bit_and_logic_instr_exec (
  input  wire        clock_i,
  input  wire        rst_b_i,
  input  wire        instr_valid_i,
  input  wire [11:0] instr_i,
  output wire        instr_ready_o,
  output reg  [7:0]  acc_o,
  output reg         zero_flag_o,
  output reg         carry_flag_o,
  output reg         nibble_overflow_flag_o,
  output reg         squash_o,
  output reg         done_o,
  input  wire [4:0]  peek_addr_i,
  output reg  [7:0]  peek_data_o
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg  [7:0] file_mem [0:`FILE_ENTRIES-1];
  wire [4:0] faddr = instr_i[`FLD_FILE_MSB:`FLD_FILE_LSB];
  wire [7:0] file_val = file_mem[faddr];

  wire [7:0] result;
  wire       wr_acc;
  wire       wr_file;
  wire       upd_zero;
  wire       upd_carry;
  wire       carry;
  wire       nibble_ovf;
  wire       skip;

  alu_unit u_alu (
    .instr_i      (instr_i),
    .file_val_i   (file_val),
    .acc_i        (acc_o),
    .result_o     (result),
    .wr_acc_o     (wr_acc),
    .wr_file_o    (wr_file),
    .upd_zero_o   (upd_zero),
    .upd_carry_o  (upd_carry),
    .carry_o      (carry),
    .nibble_ovf_o (nibble_ovf),
    .skip_o       (skip)
  );

  // ****************************************************************
  // Execute control
  // ****************************************************************
  // A word arriving while squash is pending is the prefetched one: it is
  // consumed as a no-op so the skipping instruction costs two cycles.
  reg  pending_squash;
  wire exec = instr_valid_i & ~pending_squash;

  assign instr_ready_o = 1'b1;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pending_squash <= 1'b0;
      squash_o       <= 1'b0;
      done_o         <= 1'b0;
    end else begin
      done_o   <= instr_valid_i;
      squash_o <= instr_valid_i & pending_squash;
      if (instr_valid_i) begin
        pending_squash <= exec & skip;
      end
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_o                  <= `ACC_RESET;
      zero_flag_o            <= 1'b0;
      carry_flag_o           <= 1'b0;
      nibble_overflow_flag_o <= 1'b0;
    end else if (exec) begin
      if (wr_acc) begin
        acc_o <= result;
      end
      if (upd_zero) begin
        zero_flag_o <= (result == 8'h00);
      end
      if (upd_carry) begin
        carry_flag_o           <= carry;
        nibble_overflow_flag_o <= nibble_ovf;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `FILE_ENTRIES; gi = gi + 1) begin : g_file
      always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          file_mem[gi] <= 8'h00;
        end else if (exec && wr_file && faddr == gi) begin
          file_mem[gi] <= result;
        end
      end
    end
  endgenerate

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      peek_data_o <= 8'h00;
    end else begin
      peek_data_o <= file_mem[peek_addr_i];
    end
  end

endmodule

// ### hw/bit_logic_exec_defines.vh
// Opcode patterns, field positions and flag positions of the execute block
`ifndef BIT_LOGIC_EXEC_DEFINES_VH
`define BIT_LOGIC_EXEC_DEFINES_VH

`define OP_BIT_FORCE_ONE   4'h5
`define OP_SKIP_BIT_ZERO   4'h6
`define OP_SKIP_BIT_ONE    4'h7
`define OP_OR_LITERAL      4'hd
`define OP_LOAD_LITERAL    4'hc
`define OP_OR_FILE         6'h04
`define OP_COPY_FILE       6'h08
`define OP_SUB_ACC         6'h02
`define OP_NIBBLE_EXCHANGE 6'h0e

`define FLD_FILE_LSB       0
`define FLD_FILE_MSB       4
`define FLD_DEST_BIT       5
`define FLD_BIT_LSB        5
`define FLD_BIT_MSB        7
`define FLD_LIT_MSB        7

`define FLAG_CARRY         0
`define FLAG_NIBBLE_OVF    1
`define FLAG_ZERO          2

`define ACC_RESET          8'h00
`define FLAGS_RESET        3'h0
`define FILE_ENTRIES       32

`endif

// ### hw/alu_unit.v
// Combinational result and flag unit for the execute block
`timescale 1ns/1ps
`include "bit_logic_exec_defines.vh"

module alu_unit (
  input  wire [11:0] instr_i,
  input  wire [7:0]  file_val_i,
  input  wire [7:0]  acc_i,
  output reg  [7:0]  result_o,
  output reg         wr_acc_o,
  output reg         wr_file_o,
  output reg         upd_zero_o,
  output reg         upd_carry_o,
  output reg         carry_o,
  output reg         nibble_ovf_o,
  output reg         skip_o
);

  wire [3:0] top4   = instr_i[11:8];
  wire [5:0] top6   = instr_i[11:6];
  wire [2:0] bsel   = instr_i[`FLD_BIT_MSB:`FLD_BIT_LSB];
  wire       dest   = instr_i[`FLD_DEST_BIT];
  wire [7:0] lit    = instr_i[`FLD_LIT_MSB:0];
  wire       bitval = file_val_i[bsel];
  // Carry out of f + ~w + 1 is the inverted borrow
  wire [8:0] diff   = {1'b0, file_val_i} + {1'b0, ~acc_i} + 9'h001;
  wire [4:0] ldiff  = {1'b0, file_val_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;

  always @* begin
    result_o     = 8'h00;
    wr_acc_o     = 1'b0;
    wr_file_o    = 1'b0;
    upd_zero_o   = 1'b0;
    upd_carry_o  = 1'b0;
    carry_o      = diff[8];
    nibble_ovf_o = ldiff[4];
    skip_o       = 1'b0;
    case (top4)
      `OP_BIT_FORCE_ONE: begin
        result_o  = file_val_i | (8'h01 << bsel);
        wr_file_o = 1'b1;
      end
      `OP_SKIP_BIT_ZERO: skip_o = ~bitval;
      `OP_SKIP_BIT_ONE:  skip_o = bitval;
      `OP_OR_LITERAL: begin
        result_o   = acc_i | lit;
        wr_acc_o   = 1'b1;
        upd_zero_o = 1'b1;
      end
      `OP_LOAD_LITERAL: begin
        result_o = lit;
        wr_acc_o = 1'b1;
      end
      default: begin
        case (top6)
          `OP_OR_FILE: begin
            result_o   = acc_i | file_val_i;
            upd_zero_o = 1'b1;
          end
          `OP_COPY_FILE: begin
            result_o   = file_val_i;
            upd_zero_o = 1'b1;
          end
          `OP_SUB_ACC: begin
            result_o    = diff[7:0];
            upd_zero_o  = 1'b1;
            upd_carry_o = 1'b1;
          end
          `OP_NIBBLE_EXCHANGE: begin
            result_o = {file_val_i[3:0], file_val_i[7:4]};
          end
          default: result_o = 8'h00;
        endcase
        if (top6 == `OP_OR_FILE || top6 == `OP_COPY_FILE ||
            top6 == `OP_SUB_ACC || top6 == `OP_NIBBLE_EXCHANGE) begin
          wr_acc_o  = ~dest;
          wr_file_o = dest;
        end
      end
    endcase
  end

endmodule

// ### sim/exec_checker_sva.sv
// Port assertions for the execute block
`timescale 1ns/1ps
module exec_checker (
  input wire        clock_i,
  input wire        rst_b_i,
  input wire        instr_valid_i,
  input wire [11:0] instr_i,
  input wire        instr_ready_o,
  input wire [7:0]  acc_o,
  input wire        zero_flag_o,
  input wire        carry_flag_o,
  input wire        nibble_overflow_flag_o,
  input wire        squash_o,
  input wire        done_o
);
  wire [2:0] fl = {zero_flag_o, carry_flag_o, nibble_overflow_flag_o};
  wire       tk = instr_valid_i;
  wire [3:0] op = instr_i[11:8];
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  property p_rdy; instr_ready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  property p_done; tk |=> done_o; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_idle; !tk |=> !done_o; endproperty
  a_idle: assert property (p_idle) else $error("stray done");
  property p_sq; squash_o |-> done_o && $stable({acc_o, fl}); endproperty
  a_sq: assert property (p_sq) else $error("squash moved");
  property p_ld;
    tk && op == 4'hc |=> squash_o || acc_o == $past(instr_i[7:0]);
  endproperty
  a_ld: assert property (p_ld) else $error("load");
  property p_or;
    tk && op == 4'hd |=> squash_o || (acc_o == ($past(acc_o) |
      $past(instr_i[7:0])) && zero_flag_o == (acc_o == 8'h00));
  endproperty
  a_or: assert property (p_or) else $error("or literal");
  property p_keep;
    tk && op inside {4'h5, 4'h6, 4'h7, 4'hc} |=> $stable(fl);
  endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_swp; tk && instr_i[11:6] == 6'h0e |=> $stable(fl); endproperty
  a_swp: assert property (p_swp) else $error("swap flags");
  c_sq: cover property (squash_o);
  c_sub: cover property (tk && instr_i[11:6] == 6'h02);
  c_zc: cover property (zero_flag_o && carry_flag_o);
endmodule

// ### sim/fetch_model.sv
// Program fetch stage model that feeds instruction words
`timescale 1ns/1ps
module fetch_model (
  input  wire         clock_i,
  output logic        valid_o = 1'b0,
  output logic [11:0] instr_o = 12'h000
);
  // Idle cycles scramble the word so a stale one never looks valid
  task automatic idle;
    @(posedge clock_i);
    valid_o <= 1'b0;
    instr_o <= ~instr_o;
  endtask
  task automatic issue(input logic [11:0] w, input int gap);
    repeat (gap) idle;
    @(posedge clock_i);
    valid_o <= 1'b1;
    instr_o <= w;
  endtask
endmodule

// ### sim/tb_bit_and_logic_instr_exec.sv
// Self-checking bench for the execute block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_bit_and_logic_instr_exec;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [4:0]  peek_addr_i = 5'h00;
  wire         instr_valid_i, instr_ready_o, zero_flag_o, carry_flag_o;
  wire         nibble_overflow_flag_o, squash_o, done_o;
  wire  [11:0] instr_i;
  wire  [7:0]  acc_o, peek_data_o;
  wire  [10:0] st = {acc_o, zero_flag_o, carry_flag_o, nibble_overflow_flag_o};
  logic [7:0]  mem [32];
  logic [7:0]  acc = 8'h00;
  logic        z = 1'b0, c = 1'b0, novf = 1'b0, skp = 1'b0;
  int          fails = 0, tests_run = 0;
  logic [11:0] hand [8] = '{12'hc00, 12'hd00, 12'hc07, 12'h0a1, 12'h221,
    12'h761, 12'hc55, 12'h3a2};
  logic [11:0] base [9] = '{12'h500, 12'h600, 12'h700, 12'hd00, 12'hc00,
    12'h100, 12'h200, 12'h080, 12'h380};
  always #4 clock_i = ~clock_i;
  fetch_model u_fetch_model (.clock_i(clock_i), .valid_o(instr_valid_i),
    .instr_o(instr_i));
  bit_and_logic_instr_exec u_bit_and_logic_instr_exec (.*);
  task automatic step(input logic [11:0] w, input int gap);
    logic [7:0] f, r;
    logic [4:0] a, t;
    logic       sq, dw, zu;
    a = w[4:0];
    f = mem[a];
    r = f;
    {sq, skp, dw, zu} = {skp, 3'b000};
    if (!sq) casez (w)
      12'b0101????????: mem[a][w[7:5]] = 1'b1;
      12'b0110????????: skp = !f[w[7:5]];
      12'b0111????????: skp = f[w[7:5]];
      12'b1100????????: acc = w[7:0];
      12'b1101????????: {acc, z} = {acc | w[7:0], (acc | w[7:0]) == 8'h00};
      12'b000100??????: {dw, zu, r} = {2'b11, acc | f};
      12'b001000??????: {dw, zu} = 2'b11;
      12'b001110??????: {dw, r} = {1'b1, f[3:0], f[7:4]};
      12'b000010??????: begin
        t = {1'b0, f[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        {c, r} = {1'b0, f} + {1'b0, ~acc} + 9'h001;
        {novf, dw, zu} = {t[4], 2'b11};
      end
      default: ;
    endcase
    if (dw && w[5]) mem[a] = r;
    if (dw && !w[5]) acc = r;
    if (zu) z = r == 8'h00;
    u_fetch_model.issue(w, gap);
    peek_addr_i <= a;
    u_fetch_model.idle;
    #1;
    `CHK(done_o, 1'b1)
    `CHK(squash_o, sq)
    `CHK(st, {acc, z, c, novf})
    u_fetch_model.idle;
    #1;
    `CHK(peek_data_o, mem[a])
  endtask
  task final_report;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin : main
    int i, k;
    logic [11:0] w;
    foreach (mem[j]) mem[j] = 8'h00;
    i = $urandom(32'h0dec119f);
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    foreach (hand[j]) step(hand[j], 0);
    // Opcode picked from a table so every kind is hit often
    for (i = 0; i < 400; i++) begin
      k = $urandom % 9;
      w = 12'($urandom);
      w = (w & (k < 5 ? 12'h0ff : 12'h03f)) | base[k];
      step(w, $urandom % 3);
    end
    final_report;
  end
endmodule
bind bit_and_logic_instr_exec exec_checker u_exec_checker (.*);
